/* File: uhqs_pkg.sv */
// Shared constants, encodings and carriers of the queue status logic
package uhqs_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_CMD   = 32'h0000_0000;
  localparam logic [31:0] ADDR_STS   = 32'h0000_0004;
  localparam logic [31:0] ADDR_FRAME = 32'h0000_0008;
  localparam logic [31:0] ADDR_WALK  = 32'h0000_000c;
  // Command register bits
  localparam int CMD_RUN     = 0;
  localparam int CMD_HCRESET = 1;
  localparam int CMD_GRESET  = 2;
  localparam int CMD_SUSPEND = 3;
  localparam int CMD_CONFIG  = 6;
  // Status register bits; the low five are write-one-to-clear
  localparam int STS_CINT   = 0;
  localparam int STS_EINT   = 1;
  localparam int STS_RESUME = 2;
  localparam int STS_HSE    = 3;
  localparam int STS_PFAULT = 4;
  localparam int STS_HALT   = 5;
  localparam logic [5:0] STS_W1C = 6'h1f;
  localparam logic [5:0] STS_RST = 6'h00;
  // Link pointer fields
  localparam int LP_TERM = 0;
  localparam int LP_QSEL = 1;
  localparam int LP_VF   = 2;
  localparam logic [31:0] LP_ADDR = 32'hffff_fff0;
  localparam logic [31:0] FRAME_RST = 32'h0000_0001;
  // Offset of the second word of a queue header or descriptor
  localparam logic [31:0] WORD1_OFS = 32'h0000_0004;
  // Descriptor control-status word fields
  localparam int CS_BITSTUFF = 17;
  localparam int CS_CRCTO    = 18;
  localparam int CS_DBUF     = 21;
  localparam int CS_STALL    = 22;
  localparam int CS_ACTIVE   = 23;
  localparam int CS_IOC      = 24;
  localparam int CS_ERRC     = 27;
  localparam int ERRC_W      = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    RES_ACK, RES_NULL, RES_NAK, RES_STALL, RES_TIMEOUT, RES_CRC,
    RES_BITSTUFF, RES_DBUF, RES_BADPID, RES_PIDERR, RES_BADLEN
  } uhqs_res_t;

  typedef enum logic [3:0] {
    S_IDLE, S_QH_H, S_QH_V, S_TD_L, S_TD_CS, S_EXEC, S_WB_TD, S_WB_QH
  } uhqs_state_t;

  // Outcome of one bus transaction from the transaction engine
  typedef struct packed {
    uhqs_res_t res;
    logic      setup;
  } uhqs_txn_t;

  // One memory access request
  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } uhqs_mem_t;
endpackage : uhqs_pkg

/* File: uhqs_queue_status.sv */
// Schedule walker, queue advance and command/status flag logic with AXI4-Lite registers
module uhqs_queue_status
  import uhqs_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // AXI4-Lite slave
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Schedule memory port
  output logic                     mem_req,
  output uhqs_pkg::uhqs_mem_t      mem_cmd,
  input  wire logic                mem_ack,
  input  wire logic [31:0]         mem_rdata,
  // Transaction engine
  output logic                     txn_start,
  output logic [31:0]              txn_cs,
  input  wire logic                txn_done,
  input  wire uhqs_pkg::uhqs_txn_t txn_result,
  // Frame tick and system bus abort, both from this clock domain
  input  wire logic                frame_start,
  input  wire logic                sys_abort
);
  import uhqs_pkg::*;

  logic        run, config_done, suspend;
  logic [5:0]  sts;
  logic [31:0] frame_ptr;
  logic [31:0] aw_addr, w_data;
  logic [3:0]  w_strb;
  uhqs_state_t state, next_state;
  logic        qctx, next_qctx;
  logic [31:0] cur, next_cur, qh_addr, next_qh_addr;
  logic [31:0] hlink, next_hlink, td_link, next_td_link, td_cs, next_td_cs;
  logic        adv, next_adv, next_mem_req, next_txn_start;
  uhqs_mem_t   next_mem_cmd;
  logic        ev_cint, ev_eint, ev_pfault;

  // Register bus decode
  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire ar_hs    = s_axi_arvalid & s_axi_arready;
  wire wr_cmd   = wr_fire & (aw_addr == ADDR_CMD) & w_strb[0];
  wire wr_sts   = wr_fire & (aw_addr == ADDR_STS) & w_strb[0];
  wire wr_frame = wr_fire & (aw_addr == ADDR_FRAME);
  wire wr_map   = (aw_addr == ADDR_CMD) | (aw_addr == ADDR_STS) | (aw_addr == ADDR_FRAME) | (aw_addr == ADDR_WALK);
  wire rd_map   = (s_axi_araddr == ADDR_CMD) | (s_axi_araddr == ADDR_STS)
                | (s_axi_araddr == ADDR_FRAME) | (s_axi_araddr == ADDR_WALK);
  wire soft_rst = wr_cmd & (w_data[CMD_HCRESET] | w_data[CMD_GRESET]);
  wire rst      = ~aresetn | soft_rst;
  wire [31:0] cmd_word  = {25'h0, config_done, 2'h0, suspend, 2'h0, run};
  wire [31:0] rd_word   = (s_axi_araddr == ADDR_CMD)   ? cmd_word :
                          (s_axi_araddr == ADDR_STS)   ? {26'h0, sts} :
                          (s_axi_araddr == ADDR_FRAME) ? frame_ptr :
                          (s_axi_araddr == ADDR_WALK)  ? {cur[31:4], 4'h0} | {27'h0, qctx, 4'(state)} & 32'h1f :
                          32'h0;
  wire [31:0] frame_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Write and read channels; address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
      aw_addr       <= 32'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= {s_axi_awaddr[31:2], 2'b00};
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Command and status flags; hardware set wins over a software clear
  wire       halt_ev  = ev_pfault | sys_abort;
  wire [5:0] sts_set  = {1'b0, ev_pfault, sys_abort, 1'b0, ev_eint, ev_cint};
  wire [5:0] sts_clr  = wr_sts ? (w_data[5:0] & STS_W1C) : 6'h00;
  wire       next_run = halt_ev ? 1'b0 : (wr_cmd ? w_data[CMD_RUN] : run);
  // halted once stopped and the walker has gone idle
  wire       next_halt = halt_ev | (~run & (state == S_IDLE)) | (sts[STS_HALT] & ~next_run);
  always_ff @(posedge aclk) begin
    if (rst) begin
      run         <= 1'b0;
      config_done <= 1'b0;
      suspend     <= 1'b0;
      sts         <= STS_RST;
    end else begin
      run         <= next_run;
      config_done <= config_done | (wr_cmd & w_data[CMD_CONFIG]);
      // suspend stored only, no resume signalling
      suspend     <= wr_cmd ? w_data[CMD_SUSPEND] : suspend;
      sts         <= {next_halt, (sts[4:0] & ~sts_clr[4:0]) | sts_set[4:0]};
    end
  end

  // Start pointer survives controller resets; only the bus reset restores it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_ptr <= FRAME_RST;
    end else if (wr_frame) begin
      frame_ptr <= (frame_ptr & ~frame_mask) | (w_data & frame_mask);
    end
  end

  // Effective outcome; a SETUP answered by NAK or STALL counts as time-out
  uhqs_res_t res;
  logic [ERRC_W-1:0] errc;
  assign res  = (txn_result.setup && (txn_result.res == RES_NAK || txn_result.res == RES_STALL))
                ? RES_TIMEOUT : txn_result.res;
  assign errc = td_cs[CS_ERRC +: ERRC_W];

  // Walker: fetch, execute, write back, choose the next link
  always_comb begin
    next_state     = state;
    next_qctx      = qctx;
    next_cur       = cur;
    next_qh_addr   = qh_addr;
    next_hlink     = hlink;
    next_td_link   = td_link;
    next_td_cs     = td_cs;
    next_adv       = adv;
    next_mem_req   = mem_req;
    next_mem_cmd   = mem_cmd;
    next_txn_start = 1'b0;
    ev_cint        = 1'b0;
    ev_eint        = 1'b0;
    ev_pfault      = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (run && frame_start) begin
          next_qctx = 1'b0;
          next_cur  = frame_ptr & LP_ADDR;
          next_state = frame_ptr[LP_TERM] ? S_IDLE : (frame_ptr[LP_QSEL] ? S_QH_H : S_TD_L);
        end
      end
      S_QH_H, S_QH_V, S_TD_L, S_TD_CS: begin
        if (!mem_req) begin
          next_mem_req = 1'b1;
          next_mem_cmd = '{we: 1'b0, addr: (state == S_QH_V || state == S_TD_CS) ? cur + WORD1_OFS : cur,
                           wdata: 32'h0};
        end else if (mem_ack) begin
          next_mem_req = 1'b0;
          unique case (state)
            S_QH_H: begin
              next_hlink   = mem_rdata;
              next_qh_addr = cur;
              next_qctx    = 1'b1;
              next_state   = S_QH_V;
            end
            S_QH_V: begin
              next_cur = mem_rdata & LP_ADDR;
              if (mem_rdata[LP_TERM]) begin
                next_cur   = hlink & LP_ADDR;
                next_qctx  = 1'b0;
                next_state = hlink[LP_TERM] ? S_IDLE : (hlink[LP_QSEL] ? S_QH_H : S_TD_L);
              end else begin
                next_state = mem_rdata[LP_QSEL] ? S_QH_H : S_TD_L;
              end
            end
            S_TD_L: begin
              next_td_link = mem_rdata;
              next_state   = S_TD_CS;
            end
            default: begin
              next_td_cs = mem_rdata;
              if (mem_rdata[CS_ACTIVE]) begin
                next_txn_start = 1'b1;
                next_state     = S_EXEC;
              end else begin
                // Inactive member: proceed to next entry
                next_cur   = (qctx ? hlink : td_link) & LP_ADDR;
                next_state = (qctx ? hlink[LP_TERM] : td_link[LP_TERM]) ? S_IDLE :
                             ((qctx ? hlink[LP_QSEL] : td_link[LP_QSEL]) ? S_QH_H : S_TD_L);
                next_qctx  = 1'b0;
              end
            end
          endcase
        end
      end
      S_EXEC: begin
        if (txn_done) begin
          next_adv   = 1'b0;
          next_state = S_WB_TD;
          unique case (res)
            RES_ACK, RES_NULL: begin
              next_adv              = 1'b1;
              next_td_cs[CS_ACTIVE] = 1'b0;
              ev_cint = td_cs[CS_IOC];
            end
            RES_STALL: begin
              next_td_cs[CS_ACTIVE] = 1'b0;
              next_td_cs[CS_STALL]  = 1'b1;
              ev_eint               = 1'b1;
            end
            RES_TIMEOUT, RES_CRC, RES_BITSTUFF, RES_DBUF: begin
              // count down and mark the error kind
              next_td_cs[CS_CRCTO]    = td_cs[CS_CRCTO] | (res == RES_TIMEOUT) | (res == RES_CRC);
              next_td_cs[CS_BITSTUFF] = td_cs[CS_BITSTUFF] | (res == RES_BITSTUFF);
              next_td_cs[CS_DBUF]     = td_cs[CS_DBUF] | (res == RES_DBUF);
              next_td_cs[CS_ERRC +: ERRC_W] = (errc != '0) ? errc - 1'b1 : errc;
              // stall only on the 1 to 0 step
              if (errc == ERRC_W'(1)) begin
                next_td_cs[CS_ACTIVE] = 1'b0;
                next_td_cs[CS_STALL]  = 1'b1;
                ev_eint               = 1'b1;
              end
            end
            RES_BADPID, RES_PIDERR, RES_BADLEN: begin
              ev_pfault = 1'b1;
            end
            default: begin
              // NAK: member stays active for retry
            end
          endcase
        end
      end
      S_WB_TD, S_WB_QH: begin
        if (!mem_req) begin
          next_mem_req = 1'b1;
          // header vertical link takes the descriptor link
          next_mem_cmd = (state == S_WB_TD) ? '{we: 1'b1, addr: cur + WORD1_OFS, wdata: td_cs}
                                            : '{we: 1'b1, addr: qh_addr + WORD1_OFS, wdata: td_link};
        end else if (mem_ack) begin
          next_mem_req = 1'b0;
          if (state == S_WB_TD && qctx && adv) begin
            next_state = S_WB_QH;
          end else if (state == S_WB_QH && td_link[LP_VF]) begin
            // depth first through the descriptor link
            next_cur   = td_link & LP_ADDR;
            next_state = td_link[LP_TERM] ? S_IDLE : (td_link[LP_QSEL] ? S_QH_H : S_TD_L);
          end else if (qctx) begin
            // breadth first or failed member: horizontal link
            next_cur   = hlink & LP_ADDR;
            next_qctx  = 1'b0;
            next_state = hlink[LP_TERM] ? S_IDLE : (hlink[LP_QSEL] ? S_QH_H : S_TD_L);
          end else begin
            next_cur   = td_link & LP_ADDR;
            next_state = td_link[LP_TERM] ? S_IDLE : (td_link[LP_QSEL] ? S_QH_H : S_TD_L);
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    // stop between memory accesses once run drops; an open access completes first
    if (!run && !next_mem_req && state != S_EXEC && next_state != S_WB_TD) begin
      next_state     = S_IDLE;
      next_txn_start = 1'b0; // No transaction may start once the walker has parked
    end
  end

  // Walker registers
  always_ff @(posedge aclk) begin
    if (rst) begin
      state     <= S_IDLE;
      qctx      <= 1'b0;
      cur       <= 32'h0;
      qh_addr   <= 32'h0;
      hlink     <= 32'h0;
      td_link   <= 32'h0;
      td_cs     <= 32'h0;
      adv       <= 1'b0;
      mem_req   <= 1'b0;
      mem_cmd   <= '0;
      txn_start <= 1'b0;
    end else begin
      state     <= next_state;
      qctx      <= next_qctx;
      cur       <= next_cur;
      qh_addr   <= next_qh_addr;
      hlink     <= next_hlink;
      td_link   <= next_td_link;
      td_cs     <= next_td_cs;
      adv       <= next_adv;
      mem_req   <= next_mem_req;
      mem_cmd   <= next_mem_cmd;
      txn_start <= next_txn_start;
    end
  end

  // Descriptor word offered to the transaction engine
  assign txn_cs = td_cs;
endmodule : uhqs_queue_status

/* File: uhqs_queue_status_chk.sv */
// Checker for memory port, descriptor write-back and status relations
module uhqs_queue_status_chk
  import uhqs_pkg::*;
(
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [31:0]         s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                mem_req,
  input wire uhqs_pkg::uhqs_mem_t mem_cmd,
  input wire logic                mem_ack,
  input wire logic                txn_start,
  input wire logic [31:0]         txn_cs,
  input wire logic                txn_done,
  input wire uhqs_pkg::uhqs_txn_t txn_result,
  input wire logic                sys_abort
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] cs0;
  logic [31:0] w1_addr;
  logic [31:0] rd_addr;
  uhqs_txn_t   res_q;
  logic        wb_pend;
  logic        rd_sts;
  logic        abort_seen;
  // First write after a result is the descriptor write-back
  wire              wb_now = wb_pend && mem_req && mem_cmd.we;
  wire [31:0]       nwd    = mem_cmd.wdata;
  wire [ERRC_W-1:0] errc   = cs0[CS_ERRC +: ERRC_W];
  wire              to_kind = res_q.setup && (res_q.res inside {RES_NAK, RES_STALL});
  wire              err_kind = to_kind || (res_q.res inside {RES_TIMEOUT, RES_CRC, RES_BITSTUFF, RES_DBUF});

  // Last read address before a start is the control-status word
  always_ff @(posedge aclk) begin
    if (mem_ack && !mem_cmd.we) rd_addr <= mem_cmd.addr;
    if (txn_start) cs0 <= txn_cs;
    if (txn_start) w1_addr <= rd_addr;
    if (txn_done) res_q <= txn_result;
    wb_pend <= aresetn && (txn_done || (wb_pend && !(mem_ack && mem_cmd.we)));
    rd_sts <= aresetn && ((s_axi_arvalid && s_axi_arready) ? (s_axi_araddr == ADDR_STS) : rd_sts);
    abort_seen <= aresetn && (sys_abort || (abort_seen && !(s_axi_awvalid && s_axi_awready)));
  end

  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request changed before ack");
  AST_WB_ADDR: assert property ($rose(wb_now) |-> mem_cmd.addr == w1_addr)
    else $error("write-back went to wrong address");
  AST_NAK_KEEP: assert property (wb_now && res_q.res == RES_NAK && !res_q.setup |-> nwd == cs0)
    else $error("NAK changed the descriptor");
  AST_ACK_DONE: assert property (wb_now && (res_q.res inside {RES_ACK, RES_NULL}) |->
    !nwd[CS_ACTIVE] && nwd[CS_STALL] == cs0[CS_STALL]) else $error("good completion left active");
  AST_ERR_LAST: assert property (wb_now && err_kind && errc == 1 |->
    !nwd[CS_ACTIVE] && nwd[CS_STALL] && nwd[CS_ERRC +: ERRC_W] == 0) else $error("last error not stalled");
  AST_ERR_MORE: assert property (wb_now && err_kind && errc > 1 |-> nwd[CS_ACTIVE] &&
    !nwd[CS_STALL] && nwd[CS_ERRC +: ERRC_W] == errc - 1) else $error("error counter not decremented");
  AST_SETUP_TO: assert property (wb_now && to_kind |-> nwd[CS_CRCTO])
    else $error("setup NAK or STALL not a time-out");
  AST_ABORT_HALT: assert property (s_axi_rvalid && rd_sts && abort_seen |->
    s_axi_rdata[STS_HSE] && s_axi_rdata[STS_HALT]) else $error("abort flags missing");

  cover property (wb_now && err_kind && errc == 1);
  cover property ($rose(wb_now) && res_q.res == RES_ACK);
  cover property (s_axi_rvalid && rd_sts && abort_seen);
endmodule : uhqs_queue_status_chk

bind uhqs_queue_status uhqs_queue_status_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .mem_req, .mem_cmd,
  .mem_ack, .txn_start, .txn_cs, .txn_done, .txn_result, .sys_abort);

/* File: uhqs_far_model.sv */
// Far-side model: schedule memory and bus transaction engine
module uhqs_far_model
  import uhqs_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                mem_req,
  input  wire uhqs_pkg::uhqs_mem_t mem_cmd,
  output logic                     mem_ack,
  output logic [31:0]              mem_rdata,
  input  wire logic                txn_start,
  input  wire uhqs_pkg::uhqs_txn_t res_sel,
  output logic                     txn_done,
  output uhqs_pkg::uhqs_txn_t      txn_result,
  output int                       txn_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  int          mwait = 0;
  int          twait = 0;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    txn_done = 1'b0;
    txn_result = '0;
    txn_cnt = 0;
  end

  // Ack after 0..2 idle cycles; data toggles when not valid so stale reads show
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (mwait == 0) begin
        mem_ack <= 1'b1;
        mwait <= $urandom_range(2, 0);
        if (mem_cmd.we) mem[mem_cmd.addr[7:2]] <= mem_cmd.wdata;
        else mem_rdata <= mem[mem_cmd.addr[7:2]];
      end else mwait <= mwait - 1;
    end
  end

  // Transaction finishes 1..3 cycles after start with the commanded outcome
  always @(posedge aclk) begin
    txn_done <= 1'b0;
    txn_result <= uhqs_txn_t'(~txn_result);
    if (txn_start) begin
      twait <= $urandom_range(3, 1);
      txn_cnt <= txn_cnt + 1;
    end else if (twait > 0) begin
      twait <= twait - 1;
      if (twait == 1) txn_done <= 1'b1;
      if (twait == 1) txn_result <= res_sel;
    end
  end
endmodule : uhqs_far_model

/* File: uhqs_queue_status_tb.sv */
// Self-checking bench of the queue status logic
module uhqs_queue_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uhqs_pkg::*;
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
  logic        aclk = 1'b0, aresetn = 1'b0, frame_start = 1'b0, sys_abort = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, mem_rdata, txn_cs;
  logic        mem_req, mem_ack, txn_start, txn_done;
  uhqs_mem_t   mem_cmd;
  uhqs_txn_t   txn_result;
  uhqs_txn_t   res_sel = '0;
  int          txn_cnt, miscompares = 0, tests_run = 0, cycles = 0;

  uhqs_queue_status u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req,
    .mem_cmd, .mem_ack, .mem_rdata, .txn_start, .txn_cs, .txn_done, .txn_result, .frame_start, .sys_abort);
  uhqs_far_model u_far (.aclk, .mem_req, .mem_cmd, .mem_ack, .mem_rdata, .txn_start, .res_sel,
    .txn_done, .txn_result, .txn_cnt);

  // 125 MHz clock and a hang limit well above the expected run length
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin miscompares++; test_done(); end
  end

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok = 0;
    bit w_ok = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin s_axi_awvalid <= 1'b0; aw_ok = 1; end
      if (!w_ok && s_axi_wready) begin s_axi_wvalid <= 1'b0; w_ok = 1; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Expected control-status word after one outcome
  function automatic logic [31:0] exp_cs(logic [31:0] cs, uhqs_txn_t t);
    logic [31:0] e = cs;
    uhqs_res_t   k = (t.setup && t.res inside {RES_NAK, RES_STALL}) ? RES_TIMEOUT : t.res;
    case (k)
      RES_ACK, RES_NULL: e[CS_ACTIVE] = 1'b0;
      RES_STALL: e[CS_STALL] = 1'b1;
      RES_TIMEOUT, RES_CRC, RES_BITSTUFF, RES_DBUF: begin
        e[k == RES_BITSTUFF ? CS_BITSTUFF : k == RES_DBUF ? CS_DBUF : CS_CRCTO] = 1'b1;
        if (cs[CS_ERRC +: ERRC_W] != 0) e[CS_ERRC +: ERRC_W] = cs[CS_ERRC +: ERRC_W] - 1;
        if (cs[CS_ERRC +: ERRC_W] == 1) e[CS_STALL] = 1'b1;
      end
      default: ;
    endcase
    if (e[CS_STALL]) e[CS_ACTIVE] = 1'b0;
    return e;
  endfunction : exp_cs

  // One frame: queue header at 0x40, member at 0x80, second member at 0xc0
  task automatic run_frame(input uhqs_txn_t t, input logic [31:0] cs, input bit vf, input bit empty);
    logic [31:0] d;
    logic [1:0]  r;
    int          cnt0 = txn_cnt;
    bit          adv = !empty && (t.res inside {RES_ACK, RES_NULL});
    bit          flt = !empty && (t.res inside {RES_BADPID, RES_PIDERR, RES_BADLEN});
    logic [31:0] e = empty ? cs : exp_cs(cs, t);
    {u_far.mem[16], u_far.mem[17]} = {32'h1, empty ? 32'h1 : 32'h80};
    {u_far.mem[32], u_far.mem[33], u_far.mem[48], u_far.mem[49]} = {vf ? 32'hc4 : 32'hc0, cs, 32'h1, cs};
    res_sel <= t;
    axi_wr(ADDR_FRAME, 32'h42, r);
    axi_wr(ADDR_CMD, 32'h1, r);
    @(posedge aclk) frame_start <= 1'b1;
    @(posedge aclk) frame_start <= 1'b0;
    for (int n = 0; n < 40; n++) begin
      axi_rd(ADDR_WALK, d, r);
      if (d[3:0] == 4'h0) break;
    end
    `CHK(txn_cnt - cnt0, empty ? 0 : (adv && vf) ? 2 : 1)
    `CHK(u_far.mem[33], e)
    `CHK(u_far.mem[17], (empty || !adv) ? 32'h80 >> (empty ? 7 : 0) : vf ? 32'h1 : 32'hc0)
    axi_rd(ADDR_STS, d, r);
    `CHK(d[5:0], {flt, flt, 2'b00, e[CS_STALL], adv && cs[CS_IOC]})
    axi_rd(ADDR_CMD, d, r);
    `CHK(d[0], !flt)
    axi_wr(ADDR_STS, 32'h1f, r);
    $display("frame test res=%0d setup=%0d vf=%0d empty=%0d done", t.res, t.setup, vf, empty);
  endtask : run_frame

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] cs;
    uhqs_txn_t   t;
    int          n0;
    logic [31:0] rst_cmd [2] = '{32'h2, 32'h4};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(44955));
    axi_rd(32'h10, d, r);
    `CHK(r, RESP_SLVERR)
    axi_wr(32'h10, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    // Corner outcomes: last retry, setup NAK, depth-first advance, empty queue
    run_frame('{RES_TIMEOUT, 1'b0}, 32'h0880_0000, 0, 0);
    run_frame('{RES_NAK, 1'b1}, 32'h0880_0000, 0, 0);
    run_frame('{RES_ACK, 1'b0}, 32'h0180_0000, 1, 0);
    run_frame('{RES_NAK, 1'b0}, 32'h1880_0000, 0, 1);
    for (int i = 0; i < 30; i++) begin
      t = '{uhqs_res_t'($urandom_range(10, 0)), 1'($urandom_range(1, 0))};
      cs = 32'h0080_0000;
      cs[CS_ERRC +: ERRC_W] = ERRC_W'($urandom_range(3, 0));
      cs[CS_IOC] = 1'($urandom_range(1, 0));
      run_frame(t, cs, 1'($urandom_range(1, 0)), $urandom_range(5, 0) == 0);
    end
    // Nested header at 0x00 holding the header at 0x40, then a frame pointer straight to a descriptor
    for (int i = 0; i < 2; i++) begin
      {u_far.mem[0], u_far.mem[1], u_far.mem[16], u_far.mem[17]} = {32'h1, 32'h42, 32'h1, 32'h80};
      {u_far.mem[32], u_far.mem[33], u_far.mem[48], u_far.mem[49]} = {32'hc0, 32'h80_0000, 32'h1, 32'h80_0000};
      n0 = txn_cnt;
      res_sel <= '{RES_ACK, 1'b0};
      axi_wr(ADDR_FRAME, (i == 0) ? 32'h2 : 32'h80, r);
      axi_wr(ADDR_CMD, 32'h1, r);
      @(posedge aclk) frame_start <= 1'b1;
      @(posedge aclk) frame_start <= 1'b0;
      repeat (150) @(posedge aclk);
      `CHK(txn_cnt - n0, i + 1)
      `CHK(u_far.mem[1], 32'h42)
      `CHK(u_far.mem[17], (i == 0) ? 32'hc0 : 32'h80)
      $display("link test start=%0d done", i);
    end
    // Configured flag, abort, then each reset kind
    foreach (rst_cmd[i]) begin
      axi_wr(ADDR_CMD, 32'h41, r);
      axi_wr(ADDR_CMD, 32'h01, r);
      axi_rd(ADDR_CMD, d, r);
      `CHK(d[6], 1'b1)
      @(posedge aclk) sys_abort <= 1'b1;
      @(posedge aclk) sys_abort <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_rd(ADDR_STS, d, r);
      `CHK(d[5:0], 6'h28)
      axi_wr(ADDR_CMD, rst_cmd[i], r);
      axi_rd(ADDR_CMD, d, r);
      `CHK(d[6:0], 7'h00)
      axi_rd(ADDR_STS, d, r);
      `CHK(d[5:0], 6'h20)
      $display("reset test cmd=%h done", rst_cmd[i]);
    end
    test_done();
  end
endmodule : uhqs_queue_status_tb
